/* File: inc/scd_map.svh */
// Register offsets, field positions, reset values and bus constants of the divider/status block
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH

// Register offsets
`define SCD_OFF_DIV_CH1 8'h15
`define SCD_OFF_DIV_CH2 8'h16
`define SCD_OFF_DIV_CH3 8'h17
`define SCD_OFF_STATUS 8'h18
`define SCD_OFF_RESULT_HI_CH0 8'h00
`define SCD_OFF_RESULT_HI_CH1 8'h02
`define SCD_OFF_RESULT_HI_CH2 8'h04
`define SCD_OFF_RESULT_HI_CH3 8'h06

// Divider register fields
`define SCD_SENSE_DIV_MSB 15
`define SCD_SENSE_DIV_LSB 12
`define SCD_REF_DIV_MSB 9
`define SCD_REF_DIV_LSB 0

// Status register fields
`define SCD_ERROR_SOURCE_CHANNEL_MSB 15
`define SCD_ERROR_SOURCE_CHANNEL_LSB 14
`define SCD_UNDERRANGE_BIT 13
`define SCD_OVERRANGE_BIT 12
`define SCD_READY_BIT 6

// Reset values
`define SCD_DIV_RESET 16'h0000
`define SCD_ERROR_SOURCE_CHANNEL_RESET 2'h0

// Serial bus: base target address, low bit taken from the address pin (value arbitrary)
`define SCD_BUS_ADDR_BASE 7'h30

`endif

/* File: inc/scd_pkg.sv */
// Types shared by the divider/status block
package scd_pkg;

    // Serial bus target phases
    typedef enum logic [3:0] {
        SCD_IDLE,
        SCD_ADDR,
        SCD_ACK_ADDR,
        SCD_PTR,
        SCD_ACK_PTR,
        SCD_WR_BYTE,
        SCD_ACK_WR,
        SCD_RD_BYTE,
        SCD_ACK_RD
    } scd_bus_state_t;

    typedef logic [15:0] scd_word_t;

endpackage : scd_pkg

/* File: design/scd_regs.sv */
// Divider and status register bank with its two-wire serial target
//
// How it works
// - Bits 15:12 divide the sensor input edges.
// - Bits 9:0 divide clk into reference tick.
// - Dividers reset zero, at 0x15..0x17.
// - Status 15:14 names the error channel.
// - Codes 2 and 3 only when more than two channels.
// - Error latched until status or source read.
// - Under-range error sets status bit 13.
// - Over-range error sets status bit 12.
// - Status read clears range flags.
// - Status fields read-only, reset zero.
// - Result ready sets status bit 6.
// - Bits 3..0 flag unread results ch0..3.
`timescale 1ns/10ps
`include "scd_map.svh"

module scd_regs #(
    parameter int CHANNELS = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Serial bus pins, open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_pin,
    // Sensor oscillations, channels 1 to 3
    input wire logic [2:0] sensor_clk_in,
    // Conversion core events
    input wire logic underrange_event,
    input wire logic overrange_event,
    input wire logic [1:0] event_channel,
    input wire logic result_ready_event,
    input wire logic [3:0] conv_done,
    // Path to the other registers of the device
    output logic [7:0] reg_addr,
    output logic reg_rd_strobe,
    input wire scd_pkg::scd_word_t ext_rd_data,
    output logic reg_wr_strobe,
    output scd_pkg::scd_word_t reg_wr_data,
    // Divider settings and divided ticks, channels 1 to 3
    output logic [3:0] sense_in_div_ch1,
    output logic [3:0] sense_in_div_ch2,
    output logic [3:0] sense_in_div_ch3,
    output logic [9:0] ref_clk_div_ch1,
    output logic [9:0] ref_clk_div_ch2,
    output logic [9:0] ref_clk_div_ch3,
    output logic [2:0] ref_tick,
    output logic [2:0] sense_tick
);
    import scd_pkg::*;

    localparam int NPIN = 6;

    scd_word_t div_reg [3];
    logic [NPIN-1:0] pin_s1, pin_s2, pin_s3, pin_f, pin_prev;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    scd_bus_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    scd_word_t tx;
    logic [7:0] hi_byte;
    logic half, rd_mode, nack, load_req;
    logic [1:0] error_source_channel;
    logic underrange_flag, overrange_flag, result_ready_flag;
    logic [3:0] pending_result;
    logic status_read;
    logic [3:0] hi_read;
    logic err_event;
    logic chan_ok;
    scd_word_t status_word;
    scd_word_t rd_word;

    // Pins pass three flops; a level counts once the last two agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1 <= '1;
            pin_s2 <= '1;
            pin_s3 <= '1;
            pin_f <= '1;
            pin_prev <= '1;
        end else begin
            pin_s1 <= {sensor_clk_in, addr_pin, sda_in, scl_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f <= (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_f);
            pin_prev <= pin_f;
        end
    end

    assign scl_rise = pin_f[0] & ~pin_prev[0];
    assign scl_fall = ~pin_f[0] & pin_prev[0];
    // Start and stop are data edges while the clock stays high
    assign bus_start = pin_f[0] & pin_prev[0] & ~pin_f[1] & pin_prev[1];
    assign bus_stop = pin_f[0] & pin_prev[0] & pin_f[1] & ~pin_prev[1];
    assign sda_out = 1'b0;

    // Read-only status view; bits 11:8, 7 and 5:4 read zero here
    always_comb begin
        status_word = 16'h0000;
        status_word[`SCD_ERROR_SOURCE_CHANNEL_MSB:`SCD_ERROR_SOURCE_CHANNEL_LSB] = error_source_channel;
        status_word[`SCD_UNDERRANGE_BIT] = underrange_flag;
        status_word[`SCD_OVERRANGE_BIT] = overrange_flag;
        status_word[`SCD_READY_BIT] = result_ready_flag;
        status_word[3:0] = {pending_result[0], pending_result[1],
                            pending_result[2], pending_result[3]};
    end

    // Read mux; addresses outside this bank come from the rest of the device
    always_comb begin
        case (reg_addr)
            `SCD_OFF_DIV_CH1: rd_word = div_reg[0];
            `SCD_OFF_DIV_CH2: rd_word = (CHANNELS > 2) ? div_reg[1] : 16'h0000;
            `SCD_OFF_DIV_CH3: rd_word = (CHANNELS > 2) ? div_reg[2] : 16'h0000;
            `SCD_OFF_STATUS: rd_word = status_word;
            default: rd_word = ext_rd_data;
        endcase
    end

    // Serial target: sample on clock rise, act and drive on clock fall
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SCD_IDLE;
            bit_cnt <= 4'h0;
            shift_in <= 8'h00;
            tx <= 16'h0000;
            hi_byte <= 8'h00;
            half <= 1'b0;
            rd_mode <= 1'b0;
            nack <= 1'b0;
            load_req <= 1'b0;
            sda_oe <= 1'b0;
            reg_addr <= 8'h00;
            reg_wr_strobe <= 1'b0;
            reg_wr_data <= 16'h0000;
        end else begin
            load_req <= 1'b0;
            reg_wr_strobe <= 1'b0;
            if (load_req) begin
                // Word is taken one cycle after the request, the same cycle its reads clear
                tx <= rd_word;
                sda_oe <= ~rd_word[15];
            end
            if (bus_stop) begin
                state <= SCD_IDLE;
                sda_oe <= 1'b0;
            end else if (bus_start) begin
                state <= SCD_ADDR;
                bit_cnt <= 4'h0;
                half <= 1'b0;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (state == SCD_ACK_RD) begin
                    nack <= pin_f[1];
                end else if (state != SCD_IDLE && state != SCD_ACK_ADDR &&
                             state != SCD_ACK_PTR && state != SCD_ACK_WR) begin
                    shift_in <= {shift_in[6:0], pin_f[1]};
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (scl_fall) begin
                case (state)
                    SCD_ADDR: begin
                        if (bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            if (shift_in[7:1] == {6'(`SCD_BUS_ADDR_BASE >> 1), pin_f[2]}) begin
                                rd_mode <= shift_in[0];
                                sda_oe <= 1'b1;
                                state <= SCD_ACK_ADDR;
                            end else begin
                                state <= SCD_IDLE;
                            end
                        end
                    end
                    SCD_ACK_ADDR: begin
                        sda_oe <= 1'b0;
                        if (rd_mode) begin
                            load_req <= 1'b1;
                            state <= SCD_RD_BYTE;
                        end else begin
                            state <= SCD_PTR;
                        end
                    end
                    SCD_PTR: begin
                        if (bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            reg_addr <= shift_in;
                            sda_oe <= 1'b1;
                            state <= SCD_ACK_PTR;
                        end
                    end
                    SCD_ACK_PTR, SCD_ACK_WR: begin
                        sda_oe <= 1'b0;
                        state <= SCD_WR_BYTE;
                    end
                    SCD_WR_BYTE: begin
                        if (bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            sda_oe <= 1'b1;
                            state <= SCD_ACK_WR;
                            half <= ~half;
                            if (!half) begin
                                hi_byte <= shift_in;
                            end else begin
                                reg_wr_strobe <= 1'b1;
                                reg_wr_data <= {hi_byte, shift_in};
                            end
                        end
                    end
                    SCD_RD_BYTE: begin
                        if (bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            sda_oe <= 1'b0;
                            state <= SCD_ACK_RD;
                        end else begin
                            tx <= {tx[14:0], 1'b0};
                            sda_oe <= ~tx[14];
                        end
                    end
                    SCD_ACK_RD: begin
                        if (nack) begin
                            sda_oe <= 1'b0;
                            state <= SCD_IDLE;
                        end else if (!half) begin
                            tx <= {tx[14:0], 1'b0};
                            sda_oe <= ~tx[14];
                            half <= 1'b1;
                            state <= SCD_RD_BYTE;
                        end else begin
                            // Next word of a burst
                            reg_addr <= reg_addr + 8'h01;
                            load_req <= 1'b1;
                            half <= 1'b0;
                            state <= SCD_RD_BYTE;
                        end
                    end
                    default: state <= state;
                endcase
            end
        end
    end

    assign reg_rd_strobe = load_req;

    // Divider registers; a word lands as the ack of its low byte begins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_reg[0] <= `SCD_DIV_RESET;
            div_reg[1] <= `SCD_DIV_RESET;
            div_reg[2] <= `SCD_DIV_RESET;
        end else if (reg_wr_strobe) begin
            // A write to the status offset falls through and changes nothing
            case (reg_addr)
                `SCD_OFF_DIV_CH1: div_reg[0] <= reg_wr_data;
                `SCD_OFF_DIV_CH2: if (CHANNELS > 2) div_reg[1] <= reg_wr_data;
                `SCD_OFF_DIV_CH3: if (CHANNELS > 2) div_reg[2] <= reg_wr_data;
                default: div_reg[0] <= div_reg[0];
            endcase
        end
    end

    assign sense_in_div_ch1 = div_reg[0][`SCD_SENSE_DIV_MSB:`SCD_SENSE_DIV_LSB];
    assign sense_in_div_ch2 = div_reg[1][`SCD_SENSE_DIV_MSB:`SCD_SENSE_DIV_LSB];
    assign sense_in_div_ch3 = div_reg[2][`SCD_SENSE_DIV_MSB:`SCD_SENSE_DIV_LSB];
    assign ref_clk_div_ch1 = div_reg[0][`SCD_REF_DIV_MSB:`SCD_REF_DIV_LSB];
    assign ref_clk_div_ch2 = div_reg[1][`SCD_REF_DIV_MSB:`SCD_REF_DIV_LSB];
    assign ref_clk_div_ch3 = div_reg[2][`SCD_REF_DIV_MSB:`SCD_REF_DIV_LSB];

    // Per-channel dividers; a zero field is reserved, so it simply stops the tick
    for (genvar g = 0; g < 3; g++) begin : g_div
        logic [9:0] ref_cnt;
        logic [3:0] sense_cnt;
        logic [9:0] ref_div;
        logic [3:0] sense_div;
        logic sense_edge;
        assign ref_div = div_reg[g][`SCD_REF_DIV_MSB:`SCD_REF_DIV_LSB];
        assign sense_div = div_reg[g][`SCD_SENSE_DIV_MSB:`SCD_SENSE_DIV_LSB];
        assign sense_edge = pin_f[3+g] & ~pin_prev[3+g];

        // Reference tick: one pulse every ref_div clocks
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                ref_cnt <= 10'h000;
                ref_tick[g] <= 1'b0;
            end else if (ref_div == 10'h000) begin
                ref_cnt <= 10'h000;
                ref_tick[g] <= 1'b0;
            end else if (ref_cnt >= ref_div - 10'h001) begin
                ref_cnt <= 10'h000;
                ref_tick[g] <= 1'b1;
            end else begin
                ref_cnt <= ref_cnt + 10'h001;
                ref_tick[g] <= 1'b0;
            end
        end

        // Sensor tick: one pulse every sense_div sensor rising edges
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                sense_cnt <= 4'h0;
                sense_tick[g] <= 1'b0;
            end else if (sense_div == 4'h0) begin
                sense_cnt <= 4'h0;
                sense_tick[g] <= 1'b0;
            end else if (sense_edge && sense_cnt >= sense_div - 4'h1) begin
                sense_cnt <= 4'h0;
                sense_tick[g] <= 1'b1;
            end else begin
                sense_cnt <= sense_edge ? sense_cnt + 4'h1 : sense_cnt;
                sense_tick[g] <= 1'b0;
            end
        end
    end

    // Read side effects, taken in the cycle the word is loaded
    assign status_read = load_req && reg_addr == `SCD_OFF_STATUS;
    assign hi_read[0] = load_req && reg_addr == `SCD_OFF_RESULT_HI_CH0;
    assign hi_read[1] = load_req && reg_addr == `SCD_OFF_RESULT_HI_CH1;
    assign hi_read[2] = load_req && reg_addr == `SCD_OFF_RESULT_HI_CH2;
    assign hi_read[3] = load_req && reg_addr == `SCD_OFF_RESULT_HI_CH3;
    // Two-channel builds drop events that name channels 2 and 3
    assign chan_ok = (CHANNELS > 2) || !event_channel[1];
    assign err_event = (underrange_event || overrange_event) && chan_ok;

    // Error channel and range flags; a new error wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            error_source_channel <= `SCD_ERROR_SOURCE_CHANNEL_RESET;
            underrange_flag <= 1'b0;
            overrange_flag <= 1'b0;
        end else begin
            if (err_event) begin
                error_source_channel <= event_channel;
            end
            if (underrange_event && chan_ok) begin
                underrange_flag <= 1'b1;
            end else if (status_read || hi_read[error_source_channel]) begin
                underrange_flag <= 1'b0;
            end
            if (overrange_event && chan_ok) begin
                overrange_flag <= 1'b1;
            end else if (status_read || hi_read[error_source_channel]) begin
                overrange_flag <= 1'b0;
            end
        end
    end

    // Result ready and unread-result flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            result_ready_flag <= 1'b0;
            pending_result <= 4'h0;
        end else begin
            if (result_ready_event) begin
                result_ready_flag <= 1'b1;
            end else if (status_read) begin
                result_ready_flag <= 1'b0;
            end
            for (int c = 0; c < 4; c++) begin
                if (conv_done[c] && (c < CHANNELS)) begin
                    pending_result[c] <= 1'b1;
                end else if (hi_read[c]) begin
                    pending_result[c] <= 1'b0;
                end
            end
        end
    end

endmodule : scd_regs

/* File: test/scd_regs_chk.sv */
// Port checker of the divider/status register block
`timescale 1ns/10ps
module scd_regs_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pins
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [2:0] sensor_clk_in,
    // Register path
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd_strobe,
    input wire logic reg_wr_strobe,
    input wire scd_pkg::scd_word_t reg_wr_data,
    // Dividers and ticks
    input wire logic [3:0] sense_in_div_ch1,
    input wire logic [3:0] sense_in_div_ch3,
    input wire logic [9:0] ref_clk_div_ch1,
    input wire logic [9:0] ref_clk_div_ch3,
    input wire logic [2:0] ref_tick,
    input wire logic [2:0] sense_tick
);
    import scd_pkg::*;
    logic [9:0] ref_gap;
    logic [3:0] sense_cnt;
    logic seen;
    logic sense_q;
    scd_word_t wr_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Gaps between channel 1 ticks; any write voids the gap it falls in
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_gap <= 10'h000;
            sense_cnt <= 4'h0;
            seen <= 1'b0;
            sense_q <= 1'b0;
            wr_q <= 16'h0000;
        end else begin
            ref_gap <= ref_tick[0] ? 10'h001 : ref_gap + 10'h001;
            sense_cnt <= (sense_tick[0] ? 4'h0 : sense_cnt) + {3'h0, sensor_clk_in[0] & ~sense_q};
            seen <= (ref_tick[0] || sense_tick[0] || seen) && !reg_wr_strobe;
            sense_q <= sensor_clk_in[0];
            wr_q <= reg_wr_data;
        end
    end
    div_reset_a: assert property ($rose(reset_n) |->
        {sense_in_div_ch1, sense_in_div_ch3, ref_clk_div_ch1, ref_clk_div_ch3} == 28'h0)
        else $error("dividers not zero after reset");
    div1_write_a: assert property (reg_wr_strobe && reg_addr == 8'h15 |=>
        sense_in_div_ch1 == wr_q[15:12] && ref_clk_div_ch1 == wr_q[9:0])
        else $error("channel 1 divider write lost");
    div3_write_a: assert property (reg_wr_strobe && reg_addr == 8'h17 |=>
        sense_in_div_ch3 == wr_q[15:12] && ref_clk_div_ch3 == wr_q[9:0])
        else $error("channel 3 divider write lost");
    div_hold_a: assert property (!(reg_wr_strobe && reg_addr inside {8'h15, 8'h17}) |=>
        $stable({sense_in_div_ch1, sense_in_div_ch3, ref_clk_div_ch1, ref_clk_div_ch3}))
        else $error("divider changed without its write");
    ref_gap_a: assert property (ref_tick[0] && seen |-> ref_gap == ref_clk_div_ch1)
        else $error("reference tick spacing wrong");
    ref_zero_a: assert property (ref_clk_div_ch1 == 10'h0 &&
        $past(ref_clk_div_ch1) == 10'h0 |-> !ref_tick[0]) else $error("tick with zero divider");
    sense_gap_a: assert property (sense_tick[0] && seen |-> sense_cnt == sense_in_div_ch1)
        else $error("sensor tick spacing wrong");
    sda_drive_a: assert property (sda_out == 1'b0) else $error("data pin driven high");
    strobe_pulse_a: assert property (reg_wr_strobe || reg_rd_strobe |=>
        !reg_wr_strobe && !reg_rd_strobe) else $error("strobe longer than one cycle");
    sda_low_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("data changed while serial clock high");
    cover property (reg_wr_strobe && reg_addr == 8'h15);
    cover property (reg_rd_strobe && reg_addr == 8'h18);
    cover property (sense_tick[0] && seen);
endmodule : scd_regs_chk

bind scd_regs scd_regs_chk u_chk (.clk, .reset_n, .scl_in, .sda_out, .sda_oe, .sensor_clk_in,
    .reg_addr, .reg_rd_strobe, .reg_wr_strobe, .reg_wr_data, .sense_in_div_ch1,
    .sense_in_div_ch3, .ref_clk_div_ch1, .ref_clk_div_ch3, .ref_tick, .sense_tick);

/* File: test/scd_host.sv */
// Two-wire bus host model driving the serial pins of the block
`timescale 1ns/10ps
module scd_host #(
    parameter int HALF = 8
) (
    // Clock
    input wire logic clk,
    // Bus lines; the host only ever pulls data low
    output logic scl,
    output logic sda_pull,
    input wire logic sda_line
);
    // Idle bus: clock high, data released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge clk);
    endtask : hw
    // Data changes only mid low phase, so no false start or stop
    task automatic bit_x(input logic b, output logic r);
        hw(HALF / 2);
        sda_pull = !b;
        hw(HALF / 2);
        scl = 1'b1;
        hw(HALF / 2);
        r = sda_line;
        hw(HALF / 2);
        scl = 1'b0;
    endtask : bit_x
    task automatic start_c;
        hw(HALF / 2);
        sda_pull = 1'b0;
        hw(HALF / 2);
        scl = 1'b1;
        hw(HALF);
        sda_pull = 1'b1;
        hw(HALF);
        scl = 1'b0;
    endtask : start_c
    task automatic stop_c;
        hw(HALF / 2);
        sda_pull = 1'b1;
        hw(HALF / 2);
        scl = 1'b1;
        hw(HALF);
        sda_pull = 1'b0;
        hw(HALF);
    endtask : stop_c
    // Eight bits out, then the ninth: released to read an ack, or the host's own ack
    task automatic byte_x(input logic [7:0] tx, input logic rel, output logic [7:0] rx,
            output logic acked);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], a);
            rx[i] = a;
        end
        bit_x(rel, a);
        acked = !a;
    endtask : byte_x
    task automatic write_word(input logic [6:0] dev, input logic [7:0] p,
            input logic [15:0] d, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        start_c();
        byte_x({dev, 1'b0}, 1'b1, rx, a0);
        byte_x(p, 1'b1, rx, a1);
        byte_x(d[15:8], 1'b1, rx, a2);
        byte_x(d[7:0], 1'b1, rx, a3);
        stop_c();
        ok = a0 & a1 & a2 & a3;
    endtask : write_word
    // Pointer write, repeated start, high byte acked, low byte refused to end
    task automatic read_word(input logic [6:0] dev, input logic [7:0] p,
            output logic [15:0] d);
        logic a;
        start_c();
        byte_x({dev, 1'b0}, 1'b1, d[7:0], a);
        byte_x(p, 1'b1, d[7:0], a);
        start_c();
        byte_x({dev, 1'b1}, 1'b1, d[7:0], a);
        byte_x(8'hff, 1'b0, d[15:8], a);
        byte_x(8'hff, 1'b1, d[7:0], a);
        stop_c();
    endtask : read_word
endmodule : scd_host

/* File: test/testbench.sv */
// Self-checking bench of the divider/status register block
`timescale 1ns/10ps
`include "scd_map.svh"
module testbench;
    import scd_pkg::*;
    // Target address with the address pin tied high
    localparam logic [6:0] DEV = `SCD_BUS_ADDR_BASE | 7'h01;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic scl, host_pull, sda_out, sda_oe, reg_rd_strobe, reg_wr_strobe;
    logic [2:0] sensor_clk_in = 3'h0;
    logic underrange_event = 1'b0;
    logic overrange_event = 1'b0;
    logic [1:0] event_channel = 2'h0;
    logic result_ready_event = 1'b0;
    logic [3:0] conv_done = 4'h0;
    logic [7:0] reg_addr;
    scd_word_t reg_wr_data, ext_rd_data;
    logic [3:0] sense_in_div_ch1, sense_in_div_ch2, sense_in_div_ch3;
    logic [9:0] ref_clk_div_ch1, ref_clk_div_ch2, ref_clk_div_ch3;
    logic [2:0] ref_tick, sense_tick;
    int bad_count = 0;
    int num_checks = 0;
    // Open-drain data line with pull-up; foreign registers echo their address
    wire sda_in = !(host_pull || sda_oe);
    assign ext_rd_data = {8'ha5, reg_addr};
    always #4 clk = ~clk;
    scd_host u_host (.clk, .scl, .sda_pull(host_pull), .sda_line(sda_in));
    scd_regs u_dut (.clk, .reset_n, .scl_in(scl), .sda_in, .sda_out, .sda_oe, .addr_pin(1'b1),
        .sensor_clk_in, .underrange_event, .overrange_event, .event_channel,
        .result_ready_event, .conv_done, .reg_addr, .reg_rd_strobe, .ext_rd_data,
        .reg_wr_strobe, .reg_wr_data, .sense_in_div_ch1, .sense_in_div_ch2, .sense_in_div_ch3,
        .ref_clk_div_ch1, .ref_clk_div_ch2, .ref_clk_div_ch3, .ref_tick, .sense_tick);
    task automatic check(input string w, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", w, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] p, input scd_word_t d);
        logic ok;
        u_host.write_word(DEV, p, d, ok);
        check("write ack", 16'(ok), 16'h0001);
    endtask : wr
    task automatic rd_chk(input string w, input logic [7:0] p, input scd_word_t e);
        scd_word_t d;
        u_host.read_word(DEV, p, d);
        check(w, d, e);
    endtask : rd_chk
    // kind bit 1 under-range, bit 0 over-range
    task automatic pulse(input logic [1:0] kind, input logic [1:0] ch);
        @(negedge clk);
        event_channel = ch;
        underrange_event = kind[1];
        overrange_event = kind[0];
        @(negedge clk);
        underrange_event = 1'b0;
        overrange_event = 1'b0;
    endtask : pulse
    task automatic t_reset;
        for (int i = 0; i < 4; i++) rd_chk("reset word", 8'h15 + 8'(i), 16'h0000);
    endtask : t_reset
    // Divider values all nonzero, reserved bits zero, sensor dividers at least two
    task automatic t_dividers;
        wr(8'h15, 16'h3005);
        wr(8'h16, 16'h2002);
        wr(8'h17, 16'h4003);
        check("sense div", {sense_in_div_ch1, sense_in_div_ch2, sense_in_div_ch3},
            12'h324);
        check("ref div 1", ref_clk_div_ch1, 10'h005);
        check("ref div 3", ref_clk_div_ch3, 10'h003);
        rd_chk("div 2 word", 8'h16, 16'h2002);
    endtask : t_dividers
    // Twelve sensor edges at ten clocks each; then reference ticks over sixty clocks
    task automatic t_ticks;
        int n1, n2, n3, k;
        n1 = 0;
        n2 = 0;
        n3 = 0;
        for (int i = 0; i < 130; i++) begin
            @(negedge clk);
            sensor_clk_in = (i < 120 && (i % 10) < 5) ? 3'h7 : 3'h0;
            n1 += sense_tick[0];
            n2 += sense_tick[1];
            n3 += sense_tick[2];
        end
        check("sense ticks", {4'(n1), 4'(n2), 4'(n3)}, 12'h463);
        for (k = 0; k < 20 && ref_tick[0] !== 1'b1; k++) @(negedge clk);
        n1 = 0;
        n2 = 0;
        n3 = 0;
        repeat (60) begin
            @(negedge clk);
            n1 += ref_tick[0];
            n2 += ref_tick[1];
            n3 += ref_tick[2];
        end
        check("ref ticks", {4'(n1), 6'(n2), 6'(n3)}, {4'd12, 6'd30, 6'd20});
    endtask : t_ticks
    task automatic t_refused;
        logic ok;
        wr(8'h18, 16'hffff);
        rd_chk("status after write", 8'h18, 16'h0000);
        u_host.write_word(DEV ^ 7'h02, 8'h15, 16'h1001, ok);
        check("foreign ack", 16'(ok), 16'h0000);
        check("div kept", sense_in_div_ch1, 4'h3);
    endtask : t_refused
    task automatic t_status;
        pulse(2'b10, 2'h2);
        rd_chk("under ch2", 8'h18, 16'ha000);
        rd_chk("range cleared", 8'h18, 16'h8000);
        pulse(2'b01, 2'h3);
        rd_chk("over ch3", 8'h18, 16'hd000);
        @(negedge clk);
        result_ready_event = 1'b1;
        conv_done = 4'hf;
        @(negedge clk);
        result_ready_event = 1'b0;
        conv_done = 4'h0;
        rd_chk("ready unread", 8'h18, 16'hc04f);
        rd_chk("ready cleared", 8'h18, 16'hc00f);
        rd_chk("result ch0", 8'h00, 16'ha500);
        rd_chk("unread ch0 gone", 8'h18, 16'hc007);
        pulse(2'b10, 2'h1);
        rd_chk("result ch2", 8'h04, 16'ha504);
        rd_chk("other read keeps", 8'h18, 16'h6005);
        pulse(2'b10, 2'h1);
        rd_chk("result ch1", 8'h02, 16'ha502);
        rd_chk("source read clears", 8'h18, 16'h4001);
        pulse(2'b01, 2'h0);
        rd_chk("over ch0", 8'h18, 16'h1001);
    endtask : t_status
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    // Main sequence: reset for three clocks, idle bus before the first start
    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (6) @(negedge clk);
        t_reset();
        t_dividers();
        t_ticks();
        t_refused();
        t_status();
        close_out();
    end
    // About 25 transfers of under 1000 clocks each should end well inside this span
    initial begin
        #500000;
        bad_count++;
        close_out();
    end
endmodule : testbench
